/* File: common/wdt_pkg.sv */
// Shared constants and types for the window watchdog and its trigger source
package wdt_pkg;
    // Clock rate
    localparam int CLK_MHZ = 100;

    // Trigger glitch filter: least low time, rounded up to cycles
    localparam int T_TRIG_MIN_NS = 7000;
    localparam int TRIG_MIN_CYC_I = (T_TRIG_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int TRIG_W = 10;
    localparam logic [TRIG_W-1:0] TRIG_MIN_CYC = TRIG_MIN_CYC_I[TRIG_W-1:0];

    // Startup and watchdog reset length
    localparam int T_RESET_US = 4000;
    localparam int RESET_CYC_I = T_RESET_US * CLK_MHZ;
    localparam int CYC_W = 19;
    localparam logic [CYC_W-1:0] RESET_CYC = RESET_CYC_I[CYC_W-1:0];

    // Watchdog intervals in oscillator periods
    localparam int OSC_W = 12;
    localparam logic [OSC_W-1:0] LEAD_OSC = 12'hF6C;
    localparam logic [OSC_W-1:0] CLOSED_OSC = 12'h20F;
    localparam logic [OSC_W-1:0] OPEN_OSC = 12'h229;

    // Fallback oscillator divider, deliberately far off any valid period
    localparam int FB_W = 8;
    localparam logic [FB_W-1:0] FALLBACK_DIV = 8'h10;

    // Host trigger pulse low time, safely above the filter
    localparam int HOST_W = 11;
    localparam logic [HOST_W-1:0] HOST_PULSE_CYC = 11'h320;

    typedef enum logic [2:0] {
        ST_POWER_OFF,
        ST_STARTUP,
        ST_LEAD,
        ST_CLOSED,
        ST_OPEN,
        ST_WDRESET,
        ST_OFF
    } wd_state_t;
endpackage

/* File: common/wd_link_if.sv */
// Pin-level link between the watchdog device and the host controller
interface wd_link_if;
    logic watchdog_trigger_n;
    logic divider_strap_pin;
    logic reset_n_drv;
    logic reset_oe_n;
    logic reset_n;

    // Open drain with pull-up: low only while the device drives it
    assign reset_n = reset_oe_n ? 1'b1 : reset_n_drv;

    modport device (
        input watchdog_trigger_n,
        input divider_strap_pin,
        input reset_n,
        output reset_n_drv,
        output reset_oe_n
    );

    modport host (
        output watchdog_trigger_n,
        output divider_strap_pin,
        input reset_n
    );
endinterface

/* File: rtl/wd_device.sv */
// Window watchdog with startup reset, disable logic and regulator thermal flag
module wd_device #(
    parameter logic [wdt_pkg::CYC_W-1:0] RESET_CYC = wdt_pkg::RESET_CYC
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    wd_link_if.device link,
    input wire logic wd_osc_tick_i,
    input wire logic osc_fault_i,
    input wire logic sleep_i,
    input wire logic thermal_shutdown_i,
    input wire logic overtemp_prewarn_i,
    input wire logic overtemp_clear_i,
    input wire logic cfg_write_i,
    input wire logic cfg_wdd_i,
    output logic regulator_on_o,
    output logic low_power_ok_o,
    output logic watchdog_disable_bit_o,
    output logic regulator_overtemp_flag_o,
    output logic overtemp_irq_o,
    output logic watchdog_reset_o,
    output logic [2:0] state_o
);
    typedef struct packed {
        wdt_pkg::wd_state_t st;
        logic [wdt_pkg::OSC_W-1:0] osc_cnt;
        logic [wdt_pkg::CYC_W-1:0] cyc_cnt;
        logic [wdt_pkg::TRIG_W-1:0] trig_cnt;
        logic [wdt_pkg::FB_W-1:0] fb_cnt;
        logic disable_bit;
        logic wdd_prev;
        logic strap_hi;
        logic prewarn_prev;
        logic ot_flag;
        logic ot_irq;
        logic rst_low;
        logic wd_rst;
    } dev_state_t;

    localparam dev_state_t RST_Q = '{
        st: wdt_pkg::ST_POWER_OFF,
        osc_cnt: '0,
        cyc_cnt: '0,
        trig_cnt: '0,
        fb_cnt: '0,
        disable_bit: 1'b0,
        wdd_prev: 1'b0,
        strap_hi: 1'b0,
        prewarn_prev: 1'b0,
        ot_flag: 1'b0,
        ot_irq: 1'b0,
        rst_low: 1'b1,
        wd_rst: 1'b0
    };

    dev_state_t q;
    dev_state_t d;
    logic tick;
    logic valid_trig;

    // True on the last oscillator period of an interval
    function automatic logic last_period(input logic [wdt_pkg::OSC_W-1:0] cnt,
                                         input logic [wdt_pkg::OSC_W-1:0] lim);
        last_period = (cnt == lim - 12'h001);
    endfunction

    // Next state
    always_comb begin
        d = q;
        // Fallback oscillator replaces a broken resistor; its period is far off, so windows never fit
        if (q.fb_cnt == wdt_pkg::FALLBACK_DIV - 8'h01) begin
            d.fb_cnt = '0;
        end else begin
            d.fb_cnt = q.fb_cnt + 8'h01;
        end
        tick = osc_fault_i ? (q.fb_cnt == wdt_pkg::FALLBACK_DIV - 8'h01) : wd_osc_tick_i;
        if (tick) begin
            d.osc_cnt = q.osc_cnt + 12'h001;
        end

        // Trigger counts once when the low level has lasted the least time
        valid_trig = ~link.watchdog_trigger_n && (q.trig_cnt == wdt_pkg::TRIG_MIN_CYC - 10'h001);
        if (link.watchdog_trigger_n) begin
            d.trig_cnt = '0;
        end else if (q.trig_cnt != wdt_pkg::TRIG_MIN_CYC) begin
            d.trig_cnt = q.trig_cnt + 10'h001;
        end

        // Disable bit: a one only takes effect when the previous word also wrote one
        if (cfg_write_i) begin
            d.wdd_prev = cfg_wdd_i;
            if (cfg_wdd_i && q.wdd_prev) begin
                d.disable_bit = 1'b1;
            end else if (!cfg_wdd_i) begin
                d.disable_bit = 1'b0;
            end
        end

        // Regulator prewarning: sticky flag, set wins over clear
        d.prewarn_prev = overtemp_prewarn_i;
        d.ot_irq = overtemp_prewarn_i && !q.prewarn_prev;
        d.ot_flag = (q.ot_flag && !overtemp_clear_i) || d.ot_irq;

        d.wd_rst = 1'b0;
        case (q.st)
            wdt_pkg::ST_POWER_OFF: begin
                if (!sleep_i && !thermal_shutdown_i) begin
                    d.st = wdt_pkg::ST_STARTUP;
                    d.cyc_cnt = '0;
                    d.strap_hi = 1'b1;
                end
            end
            wdt_pkg::ST_STARTUP: begin
                d.cyc_cnt = q.cyc_cnt + 19'h00001;
                d.strap_hi = q.strap_hi && link.divider_strap_pin;
                if (q.cyc_cnt == RESET_CYC - 19'h00001) begin
                    // Lead time starts exactly where the reset is released
                    d.st = wdt_pkg::ST_LEAD;
                    d.osc_cnt = '0;
                    if (d.strap_hi) begin
                        d.disable_bit = 1'b1;
                    end
                end
            end
            wdt_pkg::ST_LEAD: begin
                if (valid_trig) begin
                    d.st = wdt_pkg::ST_CLOSED;
                    d.osc_cnt = '0;
                end else if (tick && last_period(q.osc_cnt, wdt_pkg::LEAD_OSC)) begin
                    d.st = wdt_pkg::ST_WDRESET;
                    d.cyc_cnt = '0;
                    d.wd_rst = 1'b1;
                end
            end
            wdt_pkg::ST_CLOSED: begin
                if (valid_trig) begin
                    d.st = wdt_pkg::ST_WDRESET;
                    d.cyc_cnt = '0;
                    d.wd_rst = 1'b1;
                end else if (tick && last_period(q.osc_cnt, wdt_pkg::CLOSED_OSC)) begin
                    d.st = wdt_pkg::ST_OPEN;
                    d.osc_cnt = '0;
                end
            end
            wdt_pkg::ST_OPEN: begin
                if (valid_trig) begin
                    d.st = wdt_pkg::ST_CLOSED;
                    d.osc_cnt = '0;
                end else if (tick && last_period(q.osc_cnt, wdt_pkg::OPEN_OSC)) begin
                    d.st = wdt_pkg::ST_WDRESET;
                    d.cyc_cnt = '0;
                    d.wd_rst = 1'b1;
                end
            end
            wdt_pkg::ST_WDRESET: begin
                // Pulse length is fixed in clock time, independent of the oscillator
                d.cyc_cnt = q.cyc_cnt + 19'h00001;
                if (q.cyc_cnt == RESET_CYC - 19'h00001) begin
                    d.st = wdt_pkg::ST_LEAD;
                    d.osc_cnt = '0;
                end
            end
            wdt_pkg::ST_OFF: begin
                if (!q.disable_bit) begin
                    d.st = wdt_pkg::ST_LEAD;
                    d.osc_cnt = '0;
                end
            end
            default: begin
                d.st = wdt_pkg::ST_POWER_OFF;
            end
        endcase

        // Disable parks a running watchdog; a reset pulse already begun is completed
        if (d.disable_bit && (d.st == wdt_pkg::ST_LEAD || d.st == wdt_pkg::ST_CLOSED
                || d.st == wdt_pkg::ST_OPEN)) begin
            d.st = wdt_pkg::ST_OFF;
            d.wd_rst = 1'b0;
        end

        // Sleep or thermal shutdown drops the regulator; configuration is lost with it
        if (sleep_i || thermal_shutdown_i) begin
            d.st = wdt_pkg::ST_POWER_OFF;
            d.disable_bit = 1'b0;
            d.wdd_prev = 1'b0;
            d.wd_rst = 1'b0;
        end

        // Undervoltage and watchdog reset share one open-drain output
        d.rst_low = (d.st == wdt_pkg::ST_POWER_OFF) || (d.st == wdt_pkg::ST_STARTUP)
            || (d.st == wdt_pkg::ST_WDRESET);
    end

    // State register
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= RST_Q;
        end else begin
            q <= d;
        end
    end

    // Pin drive: never drives high, the pull-up does that
    assign link.reset_n_drv = 1'b0;
    assign link.reset_oe_n = ~q.rst_low;

    // Status outputs
    assign regulator_on_o = (q.st != wdt_pkg::ST_POWER_OFF);
    assign low_power_ok_o = q.disable_bit;
    assign watchdog_disable_bit_o = q.disable_bit;
    assign regulator_overtemp_flag_o = q.ot_flag;
    assign overtemp_irq_o = q.ot_irq;
    assign watchdog_reset_o = q.wd_rst;
    assign state_o = q.st;
endmodule

/* File: rtl/wd_host.sv */
// Host controller end: issues watchdog trigger pulses and watches the reset pin
module wd_host (
    input wire logic clock_i,
    input wire logic reset_n_i,
    wd_link_if.host link,
    input wire logic kick_i,
    input wire logic strap_req_i,
    output logic busy_o,
    output logic mcu_in_reset_o
);
    typedef struct packed {
        logic [wdt_pkg::HOST_W-1:0] cnt;
        logic busy;
        logic trig_n;
        logic strap;
        logic in_reset;
    } host_state_t;

    localparam host_state_t RST_Q = '{
        cnt: '0,
        busy: 1'b0,
        trig_n: 1'b1,
        strap: 1'b0,
        in_reset: 1'b1
    };

    host_state_t q;
    host_state_t d;

    // Next state: one falling edge per kick, held low beyond the glitch filter
    always_comb begin
        d = q;
        d.strap = strap_req_i;
        d.in_reset = ~link.reset_n;
        if (q.busy) begin
            d.cnt = q.cnt + 11'h001;
            if (q.cnt == wdt_pkg::HOST_PULSE_CYC - 11'h001) begin
                d.trig_n = 1'b1;
                d.busy = 1'b0;
            end
        end else if (kick_i && link.reset_n) begin
            // Kicks are dropped while in reset; timing them into the window is the user's job
            d.trig_n = 1'b0;
            d.busy = 1'b1;
            d.cnt = '0;
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= RST_Q;
        end else begin
            q <= d;
        end
    end

    assign link.watchdog_trigger_n = q.trig_n;
    assign link.divider_strap_pin = q.strap;
    assign busy_o = q.busy;
    assign mcu_in_reset_o = q.in_reset;
endmodule

/* File: verif/wd_link_asserts.sv */
// Concurrent checks on the pins that join the watchdog and its host
module wd_link_asserts #(
    parameter logic [wdt_pkg::CYC_W-1:0] RESET_CYC = wdt_pkg::RESET_CYC
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic watchdog_trigger_n,
    input wire logic reset_n_drv,
    input wire logic reset_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] low_q;
    logic [wdt_pkg::CYC_W-1:0] run_q;
    logic up_q;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    // Run lengths of trigger low and reset low; up_q hides the longer power-up pulse
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_q <= 10'h000;
            run_q <= '0;
            up_q <= 1'b0;
        end else begin
            low_q <= watchdog_trigger_n ? 10'h000 : ((low_q == 10'h3FF) ? low_q : low_q + 10'h001);
            run_q <= reset_n ? '0 : run_q + 1'b1;
            up_q <= up_q | reset_n;
        end
    end
    a_drain_data: assert property (reset_n_drv == 1'b0)
        else $error("reset pin data is not low");
    a_startup_low: assert property ($rose(reset_n_i) |-> !reset_n [*8])
        else $error("reset pin released too early after power-up");
    a_pulse_len: assert property ($rose(reset_n) && up_q |-> run_q inside {[RESET_CYC-1:RESET_CYC+1]})
        else $error("watchdog reset pulse has wrong length");
    a_trig_long: assert property ($rose(watchdog_trigger_n) |-> low_q >= wdt_pkg::TRIG_MIN_CYC)
        else $error("host trigger pulse too short");
    a_no_early_rst: assert property (!watchdog_trigger_n && low_q < wdt_pkg::TRIG_MIN_CYC - 2 |=> !$fell(reset_n))
        else $error("reset fell before trigger was valid");
    a_lead_start: assert property ($rose(reset_n) |-> reset_n [*8])
        else $error("reset pin fell right after release");
    a_low_hold: assert property ($fell(reset_n) |-> !reset_n [*8])
        else $error("reset pulse collapsed");
    a_kick_high: assert property ($fell(watchdog_trigger_n) |-> $past(reset_n))
        else $error("host triggered while reset pin low");
    c_wd_reset: cover property ($fell(reset_n) && up_q);
    c_trigger: cover property ($rose(watchdog_trigger_n));
    c_release: cover property ($rose(reset_n) && up_q);
endmodule

/* File: verif/testbench.sv */
// Self-checking bench joining watchdog device and host across the link
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [wdt_pkg::CYC_W-1:0] RC = 19'h00032;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic tick = 1'b0;
    logic sleep = 1'b0;
    logic prew = 1'b0;
    logic pclr = 1'b0;
    logic cwr = 1'b0;
    logic cwdd = 1'b0;
    logic kick_i = 1'b0;
    logic [1:0] div = 2'h0;
    logic strap = 1'b0;
    logic ofault = 1'b0;
    logic thermal = 1'b0;
    logic reg_on, lp_ok, dis, flag, irq, wdr, busy, mrst;
    logic [2:0] st;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc_n = 0;
    int n_wdr = 0;
    int t, i, f;
    wd_link_if link();
    wd_device #(.RESET_CYC(RC)) u_wd_device (.clock_i(clock_i), .reset_n_i(reset_n_i), .link(link),
        .wd_osc_tick_i(tick), .osc_fault_i(ofault), .sleep_i(sleep), .thermal_shutdown_i(thermal),
        .overtemp_prewarn_i(prew), .overtemp_clear_i(pclr), .cfg_write_i(cwr), .cfg_wdd_i(cwdd),
        .regulator_on_o(reg_on), .low_power_ok_o(lp_ok), .watchdog_disable_bit_o(dis),
        .regulator_overtemp_flag_o(flag), .overtemp_irq_o(irq), .watchdog_reset_o(wdr), .state_o(st));
    wd_host u_wd_host (.clock_i(clock_i), .reset_n_i(reset_n_i), .link(link), .kick_i(kick_i),
        .strap_req_i(strap), .busy_o(busy), .mcu_in_reset_o(mrst));
    wd_link_asserts #(.RESET_CYC(RC)) u_wd_link_asserts (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .watchdog_trigger_n(link.watchdog_trigger_n), .reset_n_drv(link.reset_n_drv), .reset_n(link.reset_n));
    initial begin
        forever #5 clock_i = ~clock_i;
    end
    // Oscillator tick every fourth clock keeps windows long against the 700-cycle filter
    always @(negedge clock_i) begin
        div <= div + 2'h1;
        tick <= (div == 2'h3);
    end
    // Count reset pulses and cut a hang short
    always @(posedge clock_i) begin
        cyc_n <= cyc_n + 1;
        if (wdr === 1'b1) n_wdr <= n_wdr + 1;
        if (cyc_n == 70000) begin
            n_mismatch = n_mismatch + 1;
            end_of_test();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic wait_st(input logic [2:0] s, input int lim, output int n);
        n = 0;
        while (st !== s && n < lim) begin
            cyc(1);
            n++;
        end
        chk("reach", s, st);
    endtask
    // One host trigger; returns cycles from request to reset pin low, 0 if none
    task automatic kick(output int fa);
        fa = 0;
        kick_i = 1'b1;
        cyc(1);
        kick_i = 1'b0;
        chk("busy", 1, busy);
        for (int k = 1; k < 1000 && busy !== 1'b0; k++) begin
            if (fa == 0 && link.reset_n === 1'b0) fa = k;
            cyc(1);
        end
    endtask
    task automatic wr(input logic b);
        cwdd = b;
        cwr = 1'b1;
        cyc(1);
        cwr = 1'b0;
        cyc(1);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        t = $urandom(32'h56E36AC4);
        cyc(2);
        reset_n_i = 1'b1;
        // Startup reset then lead time
        cyc(10);
        chk("pin", 0, link.reset_n);
        chk("mrst", 1, mrst);
        wait_st(wdt_pkg::ST_LEAD, 200, t);
        chk("startup", 1, t inside {[38:44]});
        chk("pin", 1, link.reset_n);
        cyc(1);
        chk("mrst", 0, mrst);
        $display("test startup done");
        // No trigger during lead: 3948 ticks of four clocks
        wait_st(wdt_pkg::ST_WDRESET, 16500, t);
        chk("lead", 1, t inside {[15785:15800]});
        cyc(1);
        chk("pulses", 1, n_wdr);
        $display("test lead done");
        wait_st(wdt_pkg::ST_LEAD, 200, t);
        kick(f);
        chk("state", wdt_pkg::ST_CLOSED, st);
        wait_st(wdt_pkg::ST_OPEN, 2400, t);
        chk("closed", 1, t inside {[1995:2020]});
        // Open window triggers: first at its very start, then at random points
        for (i = 0; i < 3; i++) begin
            cyc(i == 0 ? 0 : $urandom_range(1200, 0));
            kick(f);
            chk("state", wdt_pkg::ST_CLOSED, st);
            wait_st(wdt_pkg::ST_OPEN, 2400, t);
        end
        $display("test window done");
        // Back-to-back triggers: second lands in the closed window
        kick(f);
        kick(f);
        chk("fall", 1, f inside {[698:705]});
        $display("test closed done");
        wait_st(wdt_pkg::ST_LEAD, 200, t);
        // Silent open window: reset comes at its end, 553 ticks of four clocks
        kick(f);
        wait_st(wdt_pkg::ST_OPEN, 2400, t);
        t = n_wdr;
        wait_st(wdt_pkg::ST_WDRESET, 2400, i);
        chk("open", 1, i inside {[2205:2216]});
        cyc(1);
        chk("pulses", t + 1, n_wdr);
        $display("test open done");
        wait_st(wdt_pkg::ST_LEAD, 200, t);
        // Disable needs two consecutive words of one; a zero breaks the pair
        wr(1);
        chk("dis", 0, dis);
        wr(0);
        wr(1);
        chk("dis", 0, dis);
        wr(1);
        chk("dis", 1, dis);
        chk("lp", 1, lp_ok);
        cyc(4);
        chk("state", wdt_pkg::ST_OFF, st);
        wr(0);
        cyc(2);
        chk("state", wdt_pkg::ST_LEAD, st);
        $display("test disable done");
        // Regulator prewarning
        prew = 1'b1;
        cyc(1);
        chk("irq", 1, irq);
        chk("flag", 1, flag);
        cyc(1);
        chk("irq", 0, irq);
        pclr = 1'b1;
        cyc(1);
        pclr = 1'b0;
        chk("flag", 0, flag);
        // New prewarning in the same cycle as a clear: the set wins
        prew = 1'b0;
        cyc(1);
        prew = 1'b1;
        pclr = 1'b1;
        cyc(1);
        pclr = 1'b0;
        chk("flag", 1, flag);
        $display("test overtemp done");
        // Sleep switches the regulator and watchdog off
        t = n_wdr;
        sleep = 1'b1;
        cyc(3);
        chk("state", wdt_pkg::ST_POWER_OFF, st);
        chk("reg", 0, reg_on);
        cyc(100);
        chk("pulses", t, n_wdr);
        $display("test sleep done");
        // Thermal shutdown keeps the regulator off after sleep ends
        thermal = 1'b1;
        sleep = 1'b0;
        cyc(3);
        chk("state", wdt_pkg::ST_POWER_OFF, st);
        // Fresh power-up with the strap held through startup parks the watchdog
        reset_n_i = 1'b0;
        thermal = 1'b0;
        strap = 1'b1;
        cyc(2);
        reset_n_i = 1'b1;
        wait_st(wdt_pkg::ST_OFF, 200, t);
        chk("strap", 1, dis);
        // Strap dropped during startup leaves the watchdog running
        reset_n_i = 1'b0;
        cyc(2);
        reset_n_i = 1'b1;
        cyc(20);
        strap = 1'b0;
        wait_st(wdt_pkg::ST_LEAD, 200, t);
        chk("strap", 0, dis);
        $display("test strap done");
        // Broken resistor: fallback period is far off, so a kick after the normal closed time still resets
        ofault = 1'b1;
        kick(f);
        chk("state", wdt_pkg::ST_CLOSED, st);
        cyc(2300);
        kick(f);
        chk("fault", 1, f inside {[698:705]});
        $display("test fault done");
        end_of_test();
    end
endmodule
